//--- psb_pkg.sv
/*
 shared constants of the per-port link summary and transceiver basic control registers:
 address map, field positions, reset values and code points.
 assumes a 16-bit APB byte address of the form 0xNooo, N being the switch port number.
*/
// Contract
// [RULE1] link summary is 8-bit read-only at 0xN030, for ports 1-4 and 7
// [RULE2] transceiver ports: bits 4:3 give actual speed, 00=10, 01=100, 10=1000
// [RULE3] external MAC port: speed field copies ext_if_control_1 bit 6, ext_if_control_0 bit 4
// [RULE4] bit 2 is duplex, 1 full; actual on transceivers, ext_if_control_0 bit 6 otherwise
// [RULE5] external MAC port: bit 1 copies transmit_pause enable, ext_if_control_0 bit 5
// [RULE6] external MAC port: bit 0 copies receive_pause enable, ext_if_control_0 bit 3
// [RULE7] transceiver pause bits need advertised pause, link up and negotiated pause
// [RULE8] space 0xN100-0xN1FF exists only on ports with a transceiver
// [RULE9] basic control is 16 bits at 0xN100-0xN101, ports 1-4
// [RULE10] bit 15 resets transceiver logic, registers kept, then clears itself
// [RULE11] bit 14 loops egress frames back into the fabric
// [RULE12] forced speed bit 13 and duplex bit 8 ignored while negotiation enabled
// [RULE13] negotiation enable bit 12 starts from a strap, software may change it
// [RULE14] bit 11 powers the transceiver down; link status may then go stale
// [RULE15] software treats link as down while power-down is set
// [RULE16] power-down going 1 to 0 triggers an internal transceiver reset
// [RULE17] software waits 1ms after clearing power-down before any access
// [RULE18] bit 10 isolates the transceiver from the switch core
// [RULE19] bit 9 restarts negotiation and clears itself once taken
// [RULE20] forced speed and negotiation enable reset values come from sampled straps
// [RULE21] self_clearing bits read 1 until the transceiver accepts, then 0
package psb_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int N_PHY = 4;
   localparam int PORT_W = 4;
   localparam int OFFS_W = 12;
   localparam int STAT_W = 8;
   localparam int CTRL_W = 16;

   localparam logic [PORT_W-1:0] PHY_PORT_FIRST = 4'h1;
   localparam logic [PORT_W-1:0] PHY_PORT_LAST = 4'h4;
   localparam logic [PORT_W-1:0] EXT_PORT = 4'h7;

   localparam logic [OFFS_W-1:0] STAT_OFFS = 12'h030;
   localparam logic [OFFS_W-1:0] CTRL_OFFS = 12'h100;
   localparam logic [3:0] PHY_SPACE_PAGE = 4'h1;

   // link summary fields
   localparam int ST_SPEED_LO = 3;
   localparam int ST_DUPLEX = 2;
   localparam int ST_TX_PAUSE = 1;
   localparam int ST_RX_PAUSE = 0;
   localparam logic [1:0] SPEED_10 = 2'h0;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;

   // ext_if_control source bits
   localparam int EXT1_SPEED_BIT = 6;
   localparam int EXT0_SPEED_BIT = 4;
   localparam int EXT0_DUPLEX_BIT = 6;
   localparam int EXT0_TX_PAUSE_BIT = 5;
   localparam int EXT0_RX_PAUSE_BIT = 3;

   // basic control fields
   localparam int BC_RESET = 15;
   localparam int BC_LOOPBACK = 14;
   localparam int BC_SPEED = 13;
   localparam int BC_AN_EN = 12;
   localparam int BC_POWER_DOWN = 11;
   localparam int BC_ISOLATE = 10;
   localparam int BC_AN_RESTART = 9;
   localparam int BC_DUPLEX = 8;
   localparam int BC_HI_LANE = 1;

   localparam logic RST_LOOPBACK = 1'b0;
   localparam logic RST_POWER_DOWN = 1'b0;
   localparam logic RST_ISOLATE = 1'b0;
   localparam logic RST_DUPLEX = 1'b1;
   localparam logic RST_STRAP_BITS = 1'b0;

   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;
endpackage

//--- psb_sync.sv
/*
 two-stage synchroniser for a bus of independent levels.
 assumes each bit changes slowly compared to the clock; no word coherence.
*/
module psb_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= d;
         sync_reg <= meta_reg;
      end
   end

   assign q = sync_reg;
endmodule

//--- psb_sc_bit.sv
/*
 one self_clearing request bit: set by software or an event, held until accepted.
 assumes the accept strobe comes from logic on the same clock.
*/
module psb_sc_bit (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic set,
   input wire logic accept,
   output logic q
);
   logic q_reg;
   logic q_next;

   // set wins over a coinciding accept
   always_comb begin
      q_next = set | (q_reg & ~accept); // RULE21
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= 1'b0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign q = q_reg;
endmodule

//--- psb_port_regs.sv
/*
 per-port link summary registers and transceiver basic control registers behind an
 APB slave, with the control outputs that steer the four transceivers.
 assumes transceiver status levels arrive asynchronously, the ext_if_control values,
 pause advertisement and accept strobes come from logic on SYS_CLK, and straps are pins.
*/
// The register offsets and the APB slave port were left to the implementer.
module psb_port_regs (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [psb_pkg::ADDR_W-1:0] PADDR,
   input wire logic [psb_pkg::DATA_W-1:0] PWDATA,
   input wire logic [psb_pkg::STRB_W-1:0] PSTRB,
   output logic [psb_pkg::DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_LINK_UP,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_SPEED_100,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_FULL_DUPLEX,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_AN_TX_PAUSE,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_AN_RX_PAUSE,
   input wire logic [2*psb_pkg::N_PHY-1:0] PHY_ADV_PAUSE,
   input wire logic [7:0] EXT_IF_CONTROL_0,
   input wire logic [7:0] EXT_IF_CONTROL_1,
   input wire logic [psb_pkg::N_PHY-1:0] STRAP_AN_ENABLE,
   input wire logic [psb_pkg::N_PHY-1:0] STRAP_SPEED_100,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_RESET_ACCEPT,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_RESTART_ACCEPT,
   output logic [psb_pkg::N_PHY-1:0] PHY_SOFT_RESET,
   output logic [psb_pkg::N_PHY-1:0] PHY_AN_RESTART,
   output logic [psb_pkg::N_PHY-1:0] PHY_LOOPBACK,
   output logic [psb_pkg::N_PHY-1:0] PHY_AN_ENABLE,
   output logic [psb_pkg::N_PHY-1:0] PHY_FORCE_100,
   output logic [psb_pkg::N_PHY-1:0] PHY_FORCE_FULL,
   output logic [psb_pkg::N_PHY-1:0] PHY_POWER_DOWN,
   output logic [psb_pkg::N_PHY-1:0] PHY_ISOLATE
);
   import psb_pkg::*;

   localparam int N_PORTS = N_PHY + 1;
   localparam int SYNC_W = 5 * N_PHY;

   // synchronised inputs
   logic [SYNC_W-1:0] phy_raw;
   logic [SYNC_W-1:0] phy_sync;
   logic [N_PHY-1:0] link_s;
   logic [N_PHY-1:0] spd_s;
   logic [N_PHY-1:0] full_s;
   logic [N_PHY-1:0] antx_s;
   logic [N_PHY-1:0] anrx_s;
   logic [2*N_PHY-1:0] strap_sync;

   assign phy_raw = {PHY_AN_RX_PAUSE, PHY_AN_TX_PAUSE, PHY_FULL_DUPLEX, PHY_SPEED_100,
                     PHY_LINK_UP};

   psb_sync #(.WIDTH(SYNC_W)) u_phy_sync (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .d(phy_raw),
      .q(phy_sync)
   );

   psb_sync #(.WIDTH(2 * N_PHY)) u_strap_sync (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .d({STRAP_SPEED_100, STRAP_AN_ENABLE}),
      .q(strap_sync)
   );

   assign link_s = phy_sync[N_PHY-1:0];
   assign spd_s = phy_sync[2*N_PHY-1:N_PHY];
   assign full_s = phy_sync[3*N_PHY-1:2*N_PHY];
   assign antx_s = phy_sync[4*N_PHY-1:3*N_PHY];
   assign anrx_s = phy_sync[5*N_PHY-1:4*N_PHY];

   // address decode
   logic [PORT_W-1:0] port_num;
   logic [OFFS_W-1:0] offs;
   logic is_phy_port;
   logic is_ext_port;
   logic [1:0] phy_idx;
   logic hit_stat;
   logic hit_phy_space;
   logic hit_ctrl;
   logic hit_any;
   logic access;
   logic wr_ctrl;

   assign port_num = PADDR[ADDR_W-1:ADDR_W-PORT_W];
   assign offs = PADDR[OFFS_W-1:0];
   assign is_phy_port = (port_num >= PHY_PORT_FIRST) && (port_num <= PHY_PORT_LAST);
   assign is_ext_port = (port_num == EXT_PORT);
   assign phy_idx = 2'(port_num - PHY_PORT_FIRST);
   assign hit_stat = (offs == STAT_OFFS) && (is_phy_port || is_ext_port); // RULE1
   assign hit_phy_space = (offs[OFFS_W-1:8] == PHY_SPACE_PAGE) && is_phy_port; // RULE8
   assign hit_ctrl = hit_phy_space && (offs[7:2] == CTRL_OFFS[7:2]); // RULE9
   assign hit_any = hit_stat || hit_phy_space;
   assign access = PSEL && PENABLE;
   // write lands at the access edge; only the upper lane holds control bits
   assign wr_ctrl = access && PWRITE && hit_ctrl && PSTRB[BC_HI_LANE];

   // strap capture after reset release
   logic [1:0] strap_cnt_reg;
   logic [1:0] strap_cnt_next;
   logic strap_load;

   assign strap_load = (strap_cnt_reg == STRAP_SETTLE);

   always_comb begin
      strap_cnt_next = strap_cnt_reg;
      if (strap_cnt_reg <= STRAP_SETTLE) begin
         strap_cnt_next = strap_cnt_reg + 2'h1;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         strap_cnt_reg <= 2'h0;
      end else begin
         strap_cnt_reg <= strap_cnt_next;
      end
   end

   // basic control storage
   logic [N_PHY-1:0] loop_reg;
   logic [N_PHY-1:0] loop_next;
   logic [N_PHY-1:0] spd_reg;
   logic [N_PHY-1:0] spd_next;
   logic [N_PHY-1:0] an_reg;
   logic [N_PHY-1:0] an_next;
   logic [N_PHY-1:0] pd_reg;
   logic [N_PHY-1:0] pd_next;
   logic [N_PHY-1:0] iso_reg;
   logic [N_PHY-1:0] iso_next;
   logic [N_PHY-1:0] dup_reg;
   logic [N_PHY-1:0] dup_next;
   logic [N_PHY-1:0] rst_set;
   logic [N_PHY-1:0] rstrt_set;
   logic [N_PHY-1:0] rst_q;
   logic [N_PHY-1:0] rstrt_q;

   always_comb begin
      loop_next = loop_reg;
      spd_next = spd_reg;
      an_next = an_reg;
      pd_next = pd_reg;
      iso_next = iso_reg;
      dup_next = dup_reg;
      for (int i = 0; i < N_PHY; i++) begin
         if (wr_ctrl && (phy_idx == 2'(i))) begin
            loop_next[i] = PWDATA[BC_LOOPBACK]; // RULE11
            spd_next[i] = PWDATA[BC_SPEED];
            an_next[i] = PWDATA[BC_AN_EN]; // RULE13
            pd_next[i] = PWDATA[BC_POWER_DOWN]; // RULE14
            iso_next[i] = PWDATA[BC_ISOLATE]; // RULE18
            dup_next[i] = PWDATA[BC_DUPLEX];
         end
      end
      // straps settle once, right after release
      if (strap_load) begin
         an_next = strap_sync[N_PHY-1:0]; // RULE20 RULE13
         spd_next = strap_sync[2*N_PHY-1:N_PHY]; // RULE20
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         loop_reg <= {N_PHY{RST_LOOPBACK}};
         spd_reg <= {N_PHY{RST_STRAP_BITS}};
         an_reg <= {N_PHY{RST_STRAP_BITS}};
         pd_reg <= {N_PHY{RST_POWER_DOWN}};
         iso_reg <= {N_PHY{RST_ISOLATE}};
         dup_reg <= {N_PHY{RST_DUPLEX}};
      end else begin
         loop_reg <= loop_next;
         spd_reg <= spd_next;
         an_reg <= an_next;
         pd_reg <= pd_next;
         iso_reg <= iso_next;
         dup_reg <= dup_next;
      end
   end

   // self_clearing requests
   always_comb begin
      for (int i = 0; i < N_PHY; i++) begin
         // software reset, or wake from power-down
         rst_set[i] = (wr_ctrl && (phy_idx == 2'(i)) && PWDATA[BC_RESET]) // RULE10
                      || (pd_reg[i] && !pd_next[i]); // RULE16
         rstrt_set[i] = wr_ctrl && (phy_idx == 2'(i)) && PWDATA[BC_AN_RESTART]; // RULE19
      end
   end

   genvar g;
   generate
      for (g = 0; g < N_PHY; g++) begin : g_sc
         psb_sc_bit u_rst (
            .clk(SYS_CLK),
            .rst_n(RESET_N),
            .set(rst_set[g]),
            .accept(PHY_RESET_ACCEPT[g]),
            .q(rst_q[g])
         );
         psb_sc_bit u_rstrt (
            .clk(SYS_CLK),
            .rst_n(RESET_N),
            .set(rstrt_set[g]),
            .accept(PHY_RESTART_ACCEPT[g]),
            .q(rstrt_q[g])
         );
      end
   endgenerate

   // effective forced mode
   logic [N_PHY-1:0] frc100_reg;
   logic [N_PHY-1:0] frc100_next;
   logic [N_PHY-1:0] frcfull_reg;
   logic [N_PHY-1:0] frcfull_next;

   always_comb begin
      // forced values only count with negotiation off
      frc100_next = spd_reg & ~an_reg; // RULE12
      frcfull_next = dup_reg & ~an_reg; // RULE12
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         frc100_reg <= '0;
         frcfull_reg <= '0;
      end else begin
         frc100_reg <= frc100_next;
         frcfull_reg <= frcfull_next;
      end
   end

   // link summary
   logic [STAT_W-1:0] stat_reg [N_PORTS];
   logic [STAT_W-1:0] stat_next [N_PORTS];

   always_comb begin
      for (int i = 0; i < N_PHY; i++) begin
         stat_next[i] = STAT_RESET;
         stat_next[i][ST_SPEED_LO+:2] = spd_s[i] ? SPEED_100 : SPEED_10; // RULE2
         stat_next[i][ST_DUPLEX] = full_s[i]; // RULE4
         stat_next[i][ST_TX_PAUSE] = (|PHY_ADV_PAUSE[2*i+:2]) && link_s[i]
                                     && antx_s[i]; // RULE7
         stat_next[i][ST_RX_PAUSE] = (|PHY_ADV_PAUSE[2*i+:2]) && link_s[i]
                                     && anrx_s[i]; // RULE7
         // powered down: hold last summary
         if (pd_reg[i]) begin
            stat_next[i] = stat_reg[i]; // RULE14
         end
      end
      stat_next[N_PHY] = STAT_RESET;
      stat_next[N_PHY][ST_SPEED_LO+:2] = {EXT_IF_CONTROL_1[EXT1_SPEED_BIT],
                                          EXT_IF_CONTROL_0[EXT0_SPEED_BIT]}; // RULE3
      stat_next[N_PHY][ST_DUPLEX] = EXT_IF_CONTROL_0[EXT0_DUPLEX_BIT]; // RULE4
      stat_next[N_PHY][ST_TX_PAUSE] = EXT_IF_CONTROL_0[EXT0_TX_PAUSE_BIT]; // RULE5
      stat_next[N_PHY][ST_RX_PAUSE] = EXT_IF_CONTROL_0[EXT0_RX_PAUSE_BIT]; // RULE6
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (int i = 0; i < N_PORTS; i++) begin
            stat_reg[i] <= STAT_RESET;
         end
      end else begin
         for (int i = 0; i < N_PORTS; i++) begin
            stat_reg[i] <= stat_next[i];
         end
      end
   end

   // APB read path and error
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic err_reg;
   logic err_next;
   logic [CTRL_W-1:0] ctrl_view;

   always_comb begin
      ctrl_view = '0;
      ctrl_view[BC_RESET] = rst_q[phy_idx]; // RULE21
      ctrl_view[BC_LOOPBACK] = loop_reg[phy_idx];
      ctrl_view[BC_SPEED] = spd_reg[phy_idx];
      ctrl_view[BC_AN_EN] = an_reg[phy_idx];
      ctrl_view[BC_POWER_DOWN] = pd_reg[phy_idx];
      ctrl_view[BC_ISOLATE] = iso_reg[phy_idx];
      ctrl_view[BC_AN_RESTART] = rstrt_q[phy_idx]; // RULE21
      ctrl_view[BC_DUPLEX] = dup_reg[phy_idx];
   end

   // answer prepared in setup, stable through access
   always_comb begin
      rdata_next = rdata_reg;
      err_next = err_reg;
      if (PSEL && !PENABLE) begin
         rdata_next = '0;
         err_next = !hit_any;
         if (!PWRITE && hit_stat) begin
            if (is_ext_port) begin
               rdata_next[STAT_W-1:0] = stat_reg[N_PHY]; // RULE1
            end else begin
               rdata_next[STAT_W-1:0] = stat_reg[phy_idx]; // RULE1
            end
         end else if (!PWRITE && hit_ctrl) begin
            rdata_next[CTRL_W-1:0] = ctrl_view; // RULE9
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_reg <= '0;
         err_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         err_reg <= err_next;
      end
   end

   assign PRDATA = rdata_reg;
   assign PREADY = 1'b1;
   assign PSLVERR = access && err_reg;

   // transceiver controls
   assign PHY_SOFT_RESET = rst_q; // RULE10
   assign PHY_AN_RESTART = rstrt_q; // RULE19
   assign PHY_LOOPBACK = loop_reg; // RULE11
   assign PHY_AN_ENABLE = an_reg;
   assign PHY_FORCE_100 = frc100_reg;
   assign PHY_FORCE_FULL = frcfull_reg;
   assign PHY_POWER_DOWN = pd_reg; // RULE14
   assign PHY_ISOLATE = iso_reg; // RULE18
endmodule

//--- psb_port_regs_end.sv
/*
 holds no logic; the port register block lives in psb_port_regs.sv.
 assumes nothing of its surroundings.
*/

//--- psb_port_regs_sva.sv
/*
 concurrent checks on the port register block pins, port 1 lanes.
 assumes a bind to psb_port_regs and a zero-wait APB slave.
*/
module psb_port_regs_sva (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [psb_pkg::ADDR_W-1:0] PADDR,
   input wire logic [psb_pkg::DATA_W-1:0] PWDATA,
   input wire logic [psb_pkg::STRB_W-1:0] PSTRB,
   input wire logic PSLVERR,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_RESET_ACCEPT,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_RESTART_ACCEPT,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_SOFT_RESET,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_AN_RESTART,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_LOOPBACK,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_AN_ENABLE,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_FORCE_100,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_FORCE_FULL,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_POWER_DOWN,
   input wire logic [psb_pkg::N_PHY-1:0] PHY_ISOLATE
);
   import psb_pkg::*;
   wire wr1 = PSEL && PENABLE && PWRITE && PADDR == 16'h1100 && PSTRB[1];
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_rst_req;
      wr1 && PWDATA[15];
   endsequence
   sequence s_rst_taken;
      PHY_SOFT_RESET[0] && PHY_RESET_ACCEPT[0] && !wr1 && !$fell(PHY_POWER_DOWN[0]);
   endsequence
   property p_rst_set;
      s_rst_req |=> PHY_SOFT_RESET[0];
   endproperty
   a_rst_set: assert property (p_rst_set) else $error("reset request not raised");
   property p_rst_hold;
      PHY_SOFT_RESET[0] && !PHY_RESET_ACCEPT[0] |=> PHY_SOFT_RESET[0];
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("reset request dropped early");
   property p_rst_drop;
      s_rst_taken |=> !PHY_SOFT_RESET[0];
   endproperty
   a_rst_drop: assert property (p_rst_drop) else $error("reset request not cleared");
   property p_rs_set;
      wr1 && PWDATA[9] |=> PHY_AN_RESTART[0];
   endproperty
   a_rs_set: assert property (p_rs_set) else $error("restart not raised");
   property p_rs_drop;
      PHY_AN_RESTART[0] && PHY_RESTART_ACCEPT[0] && !wr1 |=> !PHY_AN_RESTART[0];
   endproperty
   a_rs_drop: assert property (p_rs_drop) else $error("restart not cleared");
   property p_lanes;
      wr1 |=> PHY_LOOPBACK[0] == $past(PWDATA[14]) && PHY_ISOLATE[0] == $past(PWDATA[10])
         && PHY_POWER_DOWN[0] == $past(PWDATA[11]);
   endproperty
   a_lanes: assert property (p_lanes) else $error("control lanes wrong");
   property p_force;
      PHY_AN_ENABLE[0] |=> !PHY_FORCE_100[0] && !PHY_FORCE_FULL[0];
   endproperty
   a_force: assert property (p_force) else $error("forced mode while negotiating");
   property p_pd_exit;
      $fell(PHY_POWER_DOWN[0]) |-> ##[0:1] PHY_SOFT_RESET[0];
   endproperty
   a_pd_exit: assert property (p_pd_exit) else $error("no reset on wake");
   property p_hole;
      PSEL && !PENABLE && PADDR[15:12] == 4'h5 |=> PSLVERR;
   endproperty
   a_hole: assert property (p_hole) else $error("port 5 access not refused");
   property p_ctrl_ok;
      PSEL && !PENABLE && PADDR == 16'h1100 |=> !PSLVERR;
   endproperty
   a_ctrl_ok: assert property (p_ctrl_ok) else $error("control access refused");
endmodule

//--- psb_port_regs_bench.sv
/*
 self-checking bench for psb_port_regs: APB master, control and status scenarios.
 assumes the package constants and the hand-over timing of the block.
*/
module psb_port_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import psb_pkg::*;
   logic SYS_CLK = 1'b0;
   logic RESET_N = 1'b0;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR;
   logic [ADDR_W-1:0] PADDR = 16'h0000;
   logic [DATA_W-1:0] PWDATA = 32'h0, PRDATA;
   logic [STRB_W-1:0] PSTRB = 4'hf;
   logic [N_PHY-1:0] link = 4'h0, spd = 4'h0, dup = 4'h0, atx = 4'h0, arx = 4'h0;
   logic [7:0] adv = 8'h00, c0 = 8'h00, c1 = 8'h00;
   logic [N_PHY-1:0] s_an = 4'h5, s_sp = 4'h3, r_acc = 4'h0, a_acc = 4'h0;
   logic [N_PHY-1:0] soft_rst, restart, loopb, an_en, f100, ffull, pdown, iso;
   logic [16:0] holes [5] = '{17'h15030, 17'h17100, 17'h11200, 17'h01104, 17'h04130};
   logic [33:0] exp_q[$];
   logic [33:0] ent;
   logic [15:0] sh;
   int seed = 54;
   int fails = 0;
   int samples_checked = 0;

   always #12.5 SYS_CLK = ~SYS_CLK;

   psb_port_regs DUT (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .PHY_LINK_UP(link), .PHY_SPEED_100(spd),
      .PHY_FULL_DUPLEX(dup), .PHY_AN_TX_PAUSE(atx), .PHY_AN_RX_PAUSE(arx),
      .PHY_ADV_PAUSE(adv), .EXT_IF_CONTROL_0(c0), .EXT_IF_CONTROL_1(c1),
      .STRAP_AN_ENABLE(s_an), .STRAP_SPEED_100(s_sp), .PHY_RESET_ACCEPT(r_acc),
      .PHY_RESTART_ACCEPT(a_acc), .PHY_SOFT_RESET(soft_rst), .PHY_AN_RESTART(restart),
      .PHY_LOOPBACK(loopb), .PHY_AN_ENABLE(an_en), .PHY_FORCE_100(f100),
      .PHY_FORCE_FULL(ffull), .PHY_POWER_DOWN(pdown), .PHY_ISOLATE(iso));

   task cmp_bus(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t bus got %h expected %h", $time, got, exp);
      end
   endtask

   task cmp_pin(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t pin got %b expected %b", $time, got, exp);
      end
   endtask

   // note the expected answer, then run setup and access phases
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e,
         input logic [31:0] x);
      @(posedge SYS_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      exp_q.push_back({!w, e, x});
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      @(posedge SYS_CLK);
      while (PREADY !== 1'b1) @(posedge SYS_CLK);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task rd(input logic [15:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, 1'b0, x);
   endtask

   task pulse(input logic k);
      @(posedge SYS_CLK);
      if (k) a_acc <= 4'h1;
      else r_acc <= 4'h1;
      @(posedge SYS_CLK);
      a_acc <= 4'h0;
      r_acc <= 4'h0;
   endtask

   task give_verdict;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   always @(posedge SYS_CLK) begin
      if (PSEL && PENABLE && PREADY === 1'b1) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("BAD %0t transfer with nothing expected", $time);
         end else begin
            ent = exp_q.pop_front();
            cmp_bus({31'h0, PSLVERR}, {31'h0, ent[32]});
            if (ent[33] && !ent[32]) cmp_bus(PRDATA, ent[31:0]);
         end
      end
   end

   initial begin
      repeat (60000) @(posedge SYS_CLK);
      fails++;
      give_verdict;
   end

   initial begin
      int q;
      repeat (6) @(posedge SYS_CLK);
      RESET_N <= 1'b1;
      repeat (6) @(posedge SYS_CLK);
      for (int p = 0; p < 4; p++) rd({4'(p + 1), 12'h100}, {16'h0, 2'b00, s_sp[p], s_an[p],
         4'h1, 8'h00});
      cmp_bus({28'h0, an_en}, {28'h0, s_an});
      for (int i = 0; i < 8; i++) begin
         q = i % 4;
         sh = 16'($random(seed)) & 16'h6500;
         sh[12] = i[0];
         apb(1'b1, {4'(q + 1), 12'h100}, {16'h0, sh}, 1'b0, 32'h0);
         rd({4'(q + 1), 12'h100}, {16'h0, sh});
         cmp_pin(loopb[q], sh[14]);
         cmp_pin(iso[q], sh[10]);
         cmp_pin(an_en[q], sh[12]);
         cmp_pin(f100[q], sh[13] & ~sh[12]);
         cmp_pin(ffull[q], sh[8] & ~sh[12]);
      end
      apb(1'b1, 16'h1100, 32'h0100, 1'b0, 32'h0);
      PSTRB <= 4'h1;
      apb(1'b1, 16'h1100, 32'h4400, 1'b0, 32'h0);
      PSTRB <= 4'hf;
      rd(16'h1100, 32'h0100);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, 16'h1100, k ? 32'h0300 : 32'h8100, 1'b0, 32'h0);
         rd(16'h1100, k ? 32'h0300 : 32'h8100);
         cmp_pin(k ? restart[0] : soft_rst[0], 1'b1);
         pulse(k[0]);
         rd(16'h1100, 32'h0100);
         cmp_pin(k ? restart[0] : soft_rst[0], 1'b0);
      end
      apb(1'b1, 16'h1100, 32'h0900, 1'b0, 32'h0);
      rd(16'h1100, 32'h0900);
      cmp_pin(pdown[0], 1'b1);
      // link rises while powered down; summary stays at the down view
      {link, spd, dup} <= 12'hfff;
      repeat (5) @(posedge SYS_CLK);
      rd(16'h1030, 32'h0);
      apb(1'b1, 16'h1100, 32'h0100, 1'b0, 32'h0);
      repeat (2) @(negedge SYS_CLK);
      cmp_pin(soft_rst[0], 1'b1);
      pulse(1'b0);
      // software keeps off the transceiver for 1 ms after wake
      repeat (40000) @(posedge SYS_CLK);
      rd(16'h1100, 32'h0100);
      for (int i = 0; i < 4; i++) begin
         c0 <= 8'($random(seed));
         c1 <= 8'($random(seed));
         repeat (4) @(posedge SYS_CLK);
         rd(16'h7030, {24'h0, 3'b000, c1[6], c0[4], c0[6], c0[5], c0[3]});
      end
      apb(1'b1, 16'h7030, 32'hff, 1'b0, 32'h0);
      rd(16'h7030, {24'h0, 3'b000, c1[6], c0[4], c0[6], c0[5], c0[3]});
      for (int i = 0; i < 8; i++) begin
         q = i % 4;
         {link, spd, dup, atx, arx} <= 20'($random(seed));
         adv <= 8'($random(seed));
         repeat (5) @(posedge SYS_CLK);
         rd({4'(q + 1), 12'h030}, {27'h0, 1'b0, spd[q], dup[q], |adv[2*q +: 2] & link[q] & atx[q],
            |adv[2*q +: 2] & link[q] & arx[q]});
      end
      for (int j = 0; j < 5; j++) apb(1'b0, holes[j][15:0], 32'h0, holes[j][16], 32'h0);
      repeat (4) @(posedge SYS_CLK);
      give_verdict;
   end
endmodule

bind psb_port_regs psb_port_regs_sva u_sva (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PSTRB(PSTRB), .PSLVERR(PSLVERR), .PHY_RESET_ACCEPT(PHY_RESET_ACCEPT),
   .PHY_RESTART_ACCEPT(PHY_RESTART_ACCEPT), .PHY_SOFT_RESET(PHY_SOFT_RESET),
   .PHY_AN_RESTART(PHY_AN_RESTART), .PHY_LOOPBACK(PHY_LOOPBACK),
   .PHY_AN_ENABLE(PHY_AN_ENABLE), .PHY_FORCE_100(PHY_FORCE_100),
   .PHY_FORCE_FULL(PHY_FORCE_FULL), .PHY_POWER_DOWN(PHY_POWER_DOWN),
   .PHY_ISOLATE(PHY_ISOLATE));
